// file: rtl/asfr_pkg.sv
// Package: register map, field layout and state types of the ADC sequencer FIFO block
package asfr_pkg;

   localparam int NSEQ      = 4;
   localparam int RES_W     = 10;
   localparam int MAX_DEPTH = 8;
   localparam int IDX_W     = 3;
   localparam int NIB_W     = 4;
   localparam int CFG_W     = 16;

   typedef logic [11:0] asfr_addr_t;
   typedef logic [31:0] asfr_word_t;
   typedef logic [IDX_W-1:0] asfr_idx_t;

   // Register byte offsets; index 0 of the per-sequencer tables is sequencer 0
   localparam asfr_addr_t OFF_OVF   = 12'h010;
   localparam asfr_addr_t OFF_UNF   = 12'h018;
   localparam asfr_addr_t OFF_SEL   [NSEQ] = '{12'hFFC, 12'h060, 12'h080, 12'h0A0};
   localparam asfr_addr_t OFF_CTL   [NSEQ] = '{12'hFFC, 12'h064, 12'h084, 12'h0A4};
   localparam asfr_addr_t OFF_FIFO  [NSEQ] = '{12'h048, 12'h068, 12'h088, 12'h0A8};
   localparam asfr_addr_t OFF_FSTAT [NSEQ] = '{12'h04C, 12'h06C, 12'h08C, 12'h0AC};

   // FIFO geometry: last slot index of each result FIFO
   localparam asfr_idx_t   LAST_IDX  [NSEQ] = '{3'h7, 3'h3, 3'h3, 3'h0};
   // Last sample slot of each sequencer
   localparam logic [1:0]  LAST_SLOT [NSEQ] = '{2'h3, 2'h3, 2'h3, 2'h0};

   // FIFO status fields
   localparam int          FULL_BIT    = 12;
   localparam int          EMPTY_BIT   = 8;
   localparam int          WR_LSB      = 4;
   localparam int          RD_LSB      = 0;
   localparam asfr_word_t  FSTAT_RESET = 32'h0000_0100;

   // Per-slot control nibble fields
   localparam int          CTL_DIFF = 0;
   localparam int          CTL_END  = 1;
   localparam int          CTL_IE   = 2;
   localparam int          CTL_TS   = 3;

   // Single-slot sequencer: width mask and hardwired last-sample marker
   localparam logic [CFG_W-1:0] SEQ3_MASK = 16'h000F;
   localparam logic [CFG_W-1:0] SEQ3_END  = 16'h0002;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       awvalid;
      asfr_addr_t awaddr;
      logic       wvalid;
      asfr_word_t wdata;
      logic [3:0] wstrb;
      logic       bready;
      logic       arvalid;
      asfr_addr_t araddr;
      logic       rready;
   } asfr_axi_in_t;

   typedef struct packed {
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      asfr_word_t rdata;
      logic [1:0] rresp;
   } asfr_axi_out_t;

   typedef struct packed {
      logic             req;
      logic [NIB_W-1:0] input_sel;
      logic             temp_source_select;
      logic             diff;
      logic [1:0]       seq;
      logic [1:0]       slot;
   } asfr_conv_req_t;

   typedef struct packed {
      logic             done;
      logic [RES_W-1:0] data;
   } asfr_conv_res_t;

   typedef enum logic [1:0] {SQ_IDLE, SQ_REQ, SQ_WAIT} asfr_seq_state_t;

   typedef struct packed {
      asfr_axi_out_t                              axo;
      asfr_addr_t                                 waddr;
      asfr_word_t                                 wdata;
      logic [3:0]                                 wstrb;
      logic                                       have_aw;
      logic                                       have_w;
      logic [NSEQ-1:1][CFG_W-1:0]                 sel;
      logic [NSEQ-1:1][CFG_W-1:0]                 ctl;
      logic [NSEQ-1:0][MAX_DEPTH-1:0][RES_W-1:0]  mem;
      logic [NSEQ-1:0][IDX_W-1:0]                 wr;
      logic [NSEQ-1:0][IDX_W-1:0]                 rd;
      logic [NSEQ-1:0]                            wwrap;
      logic [NSEQ-1:0]                            rwrap;
      logic [NSEQ-1:0]                            ovf;
      logic [NSEQ-1:0]                            unf;
      logic [NSEQ-1:1]                            pend;
      asfr_seq_state_t                            sq;
      logic [1:0]                                 act;
      logic [1:0]                                 slot;
      asfr_conv_req_t                             conv;
      logic [NSEQ-1:1]                            raw_irq;
   } asfr_state_t;

endpackage : asfr_pkg

// file: rtl/asfr_regs.sv
// ADC sample sequencer registers, result FIFOs and slot stepping behind an AXI4-Lite slave
//
// Notes on behaviour
// RQ1: FIFO status resets to 0x100, empty.
// RQ2: Status bit 12 set exactly when full.
// RQ3: Status bit 8 set when empty, resets set.
// RQ4: Status bits 7:4 show write index.
// RQ5: Status bits 3:0 show read index.
// RQ6: Reserved status bits undefined; tests ignore them.
// RQ7: Sequencers 1, 2: 16-bit four-slot config.
// RQ8: Sequencer 3: 4-bit single-slot config.
// RQ9: Software sets last-sample marker in some slot.
// RQ10: Sequencer 3 last-sample marker always reads set.
// RQ11: Result reads return slots in order.
// RQ12: Overflow and underflow recorded in status registers.
// RQ13: Sequencer 3 result reads share result layout.
// RQ14: All FIFO status registers share one layout.
// RQ15: Input select per slot applied at conversion.
// RQ16: Control nibble options apply when sequencer runs.
// RQ17: Slots after last-sample marker never converted.
// RQ18: Slot interrupt option raises raw flag.
// RQ19: Temperature option samples internal sensor instead.
// RQ20: Full and empty use indices plus wrap.
`timescale 1ns/1ps
module asfr_regs (
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   // AXI4-Lite register bus
   input  wire asfr_pkg::asfr_axi_in_t  i_axi,
   output asfr_pkg::asfr_axi_out_t      o_axi,
   // Sequencer start requests from trigger logic
   input  wire logic [3:1]              i_trigger,
   // Converter core
   output asfr_pkg::asfr_conv_req_t     o_conv,
   input  wire asfr_pkg::asfr_conv_res_t  i_conv_res,
   input  wire asfr_pkg::asfr_conv_res_t  i_seq0_res,
   // Raw per-sequencer interrupt pulses
   output logic [3:1]                   o_raw_irq
);
   import asfr_pkg::*;

   asfr_state_t s;
   asfr_state_t n;

   logic       [NSEQ-1:0] full;
   logic       [NSEQ-1:0] empty;
   asfr_word_t [NSEQ-1:0] fstat;

   for (genvar g = 0; g < NSEQ; g++) begin : g_flag
      assign empty[g] = (s.wr[g] == s.rd[g]) && (s.wwrap[g] == s.rwrap[g]); // RQ20 RQ3
      assign full[g]  = (s.wr[g] == s.rd[g]) && (s.wwrap[g] != s.rwrap[g]); // RQ20 RQ2
      // Same layout for every FIFO, reserved bits zero
      assign fstat[g] = (asfr_word_t'(full[g]) << FULL_BIT)       // RQ2 RQ14 RQ6
                      | (asfr_word_t'(empty[g]) << EMPTY_BIT)     // RQ3
                      | (asfr_word_t'(s.wr[g]) << WR_LSB)         // RQ4
                      | (asfr_word_t'(s.rd[g]) << RD_LSB);        // RQ5
   end : g_flag

   always_comb begin
      logic [NSEQ-1:0]            push;
      logic [NSEQ-1:0]            pop;
      logic [NSEQ-1:0][RES_W-1:0] push_data;
      logic                       hit;
      logic                       wok;
      logic [1:0]                 pick;
      logic [NIB_W-1:0]           cnib;
      logic [CFG_W-1:0]           merged;
      asfr_addr_t                 ra;
      push      = '0;
      pop       = '0;
      push_data = '0;
      hit       = 1'b0;
      wok       = 1'b0;
      pick      = 2'h0;
      cnib      = '0;
      merged    = '0;
      ra        = i_axi.araddr;
      n         = s;
      n.raw_irq = '0;
      n.conv.req = 1'b0;

      // Write address and data, taken in either order
      if (i_axi.awvalid && s.axo.awready) begin
         n.have_aw = 1'b1;
         n.waddr   = i_axi.awaddr;
      end
      if (i_axi.wvalid && s.axo.wready) begin
         n.have_w = 1'b1;
         n.wdata  = i_axi.wdata;
         n.wstrb  = i_axi.wstrb;
      end
      if (s.axo.bvalid && i_axi.bready) begin
         n.axo.bvalid = 1'b0;
      end
      if (s.have_aw && s.have_w) begin
         n.have_aw = 1'b0;
         n.have_w  = 1'b0;
         if (s.waddr == OFF_OVF) begin
            wok = 1'b1;
            if (s.wstrb[0]) begin
               n.ovf = s.ovf & ~s.wdata[NSEQ-1:0];
            end
         end else if (s.waddr == OFF_UNF) begin
            wok = 1'b1;
            if (s.wstrb[0]) begin
               n.unf = s.unf & ~s.wdata[NSEQ-1:0];
            end
         end else begin
            for (int q = 1; q < NSEQ; q++) begin
               if (s.waddr == OFF_SEL[q] || s.waddr == OFF_CTL[q]) begin
                  wok    = 1'b1;
                  merged = (s.waddr == OFF_SEL[q]) ? s.sel[q] : s.ctl[q];
                  if (s.wstrb[0]) begin
                     merged[7:0] = s.wdata[7:0]; // RQ7
                  end
                  if (s.wstrb[1]) begin
                     merged[15:8] = s.wdata[15:8]; // RQ7
                  end
                  if (q == NSEQ - 1) begin
                     merged = merged & SEQ3_MASK; // RQ8
                  end
                  if (s.waddr == OFF_SEL[q]) begin
                     n.sel[q] = merged;
                  end else if (q == NSEQ - 1) begin
                     n.ctl[q] = merged | SEQ3_END; // RQ10
                  end else begin
                     n.ctl[q] = merged;
                  end
               end
            end
         end
         n.axo.bvalid = 1'b1;
         n.axo.bresp  = wok ? RESP_OKAY : RESP_SLVERR;
      end

      // Read channel; a result FIFO read pops one entry
      if (s.axo.rvalid && i_axi.rready) begin
         n.axo.rvalid = 1'b0;
      end
      if (i_axi.arvalid && s.axo.arready) begin
         n.axo.rvalid = 1'b1;
         n.axo.rdata  = '0;
         if (ra == OFF_OVF) begin
            hit         = 1'b1;
            n.axo.rdata = asfr_word_t'(s.ovf);
         end else if (ra == OFF_UNF) begin
            hit         = 1'b1;
            n.axo.rdata = asfr_word_t'(s.unf);
         end else begin
            for (int q = 0; q < NSEQ; q++) begin
               if (ra == OFF_FSTAT[q]) begin
                  hit         = 1'b1;
                  n.axo.rdata = fstat[q]; // RQ14
               end else if (ra == OFF_FIFO[q]) begin
                  hit         = 1'b1;
                  pop[q]      = 1'b1;
                  n.axo.rdata = asfr_word_t'(s.mem[q][s.rd[q]]); // RQ11 RQ13
               end else if (q > 0 && ra == OFF_SEL[q]) begin
                  hit         = 1'b1;
                  n.axo.rdata = asfr_word_t'(s.sel[q]);
               end else if (q > 0 && ra == OFF_CTL[q]) begin
                  hit         = 1'b1;
                  n.axo.rdata = asfr_word_t'(s.ctl[q]);
               end
            end
         end
         n.axo.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end

      // Slot stepping; a trigger arriving on the start cycle stays pending
      n.pend = s.pend | i_trigger;
      case (s.sq)
         SQ_IDLE: begin
            for (int q = NSEQ - 1; q >= 1; q--) begin
               if (s.pend[q]) begin
                  pick = 2'(q);
               end
            end
            if (|s.pend) begin
               n.act        = pick;
               n.slot       = 2'h0;
               n.sq         = SQ_REQ;
               n.pend[pick] = i_trigger[pick];
            end
         end
         SQ_REQ: begin
            cnib                        = s.ctl[s.act][{s.slot, 2'h0} +: NIB_W];
            n.conv.req                  = 1'b1;
            n.conv.input_sel            = s.sel[s.act][{s.slot, 2'h0} +: NIB_W]; // RQ15
            n.conv.temp_source_select   = cnib[CTL_TS];                          // RQ19 RQ16
            n.conv.diff                 = cnib[CTL_DIFF] && !cnib[CTL_TS];       // RQ16
            n.conv.seq                  = s.act;
            n.conv.slot                 = s.slot;
            n.sq                        = SQ_WAIT;
         end
         SQ_WAIT: begin
            cnib = s.ctl[s.act][{s.slot, 2'h0} +: NIB_W];
            if (i_conv_res.done) begin
               push[s.act]      = 1'b1;
               push_data[s.act] = i_conv_res.data;
               if (cnib[CTL_IE]) begin
                  n.raw_irq[s.act] = 1'b1; // RQ18
               end
               // Stop at the marker; a sequence without one ends at its last slot
               if (cnib[CTL_END] || s.slot == LAST_SLOT[s.act]) begin // RQ17 RQ9
                  n.sq = SQ_IDLE;
               end else begin
                  n.slot = 2'(s.slot + 2'h1);
                  n.sq   = SQ_REQ;
               end
            end
         end
         default: begin
            n.sq = SQ_IDLE;
         end
      endcase

      push[0]      = i_seq0_res.done;
      push_data[0] = i_seq0_res.data;

      // FIFO pointers; event flags set after software clears so the set wins
      for (int q = 0; q < NSEQ; q++) begin
         if (push[q]) begin
            if (full[q]) begin
               n.ovf[q] = 1'b1; // RQ12
            end else begin
               n.mem[q][s.wr[q]] = push_data[q];
               if (s.wr[q] == LAST_IDX[q]) begin
                  n.wr[q]    = '0;
                  n.wwrap[q] = ~s.wwrap[q]; // RQ20
               end else begin
                  n.wr[q] = s.wr[q] + 3'h1;
               end
            end
         end
         if (pop[q]) begin
            if (empty[q]) begin
               n.unf[q] = 1'b1; // RQ12
            end else if (s.rd[q] == LAST_IDX[q]) begin
               n.rd[q]    = '0;
               n.rwrap[q] = ~s.rwrap[q]; // RQ11
            end else begin
               n.rd[q] = s.rd[q] + 3'h1; // RQ11
            end
         end
      end

      n.axo.awready = !n.have_aw && !n.axo.bvalid;
      n.axo.wready  = !n.have_w && !n.axo.bvalid;
      n.axo.arready = !n.axo.rvalid;

      if (!i_rst_b) begin
         n        = '0; // RQ1
         n.sq     = SQ_IDLE;
         n.ctl[NSEQ-1] = SEQ3_END; // RQ10
      end
   end

   always_ff @(posedge i_clk) begin
      s <= n;
   end

   assign o_axi     = s.axo;
   assign o_conv    = s.conv;
   assign o_raw_irq = s.raw_irq;

endmodule : asfr_regs

// file: tb/asfr_conv_model.sv
// Converter core model: answers each request after a set latency
`timescale 1ns/1ps
module asfr_conv_model (
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_b,
   // Request side and latency
   input  wire asfr_pkg::asfr_conv_req_t i_conv,
   input  wire logic [2:0]               i_lat,
   // Result side
   output asfr_pkg::asfr_conv_res_t      o_res
);
   import asfr_pkg::*;
   logic             busy;
   logic [2:0]       cnt;
   logic [RES_W-1:0] val;
   always @(posedge i_clk) begin
      o_res.done <= 1'b0;
      // Data lines toggle outside a result
      o_res.data <= ~o_res.data;
      if (!i_rst_b) begin
         busy       <= 1'b0;
         o_res.data <= '0;
      end else if (i_conv.req) begin
         busy <= 1'b1;
         cnt  <= i_lat;
         // Sensor code replaces the pin choice
         val  <= {i_conv.seq, i_conv.slot, i_conv.temp_source_select, i_conv.diff,
                  i_conv.temp_source_select ? 4'hF : i_conv.input_sel};
      end else if (busy && cnt == 3'h0) begin
         busy       <= 1'b0;
         o_res.done <= 1'b1;
         o_res.data <= val;
      end else if (busy) begin
         cnt <= cnt - 3'h1;
      end
   end
endmodule : asfr_conv_model

// file: tb/asfr_regs_asserts.sv
// Checker: read answers, conversion requests and status field relations
`timescale 1ns/1ps
module asfr_regs_asserts (
   // Clock and reset
   input wire logic                     i_clk,
   input wire logic                     i_rst_b,
   // Watched ports
   input wire asfr_pkg::asfr_axi_in_t   i_axi,
   input wire asfr_pkg::asfr_axi_out_t  o_axi,
   input wire logic [3:1]               i_trigger,
   input wire asfr_pkg::asfr_conv_req_t o_conv,
   input wire asfr_pkg::asfr_conv_res_t i_conv_res,
   input wire asfr_pkg::asfr_conv_res_t i_seq0_res,
   input wire logic [3:1]               o_raw_irq
);
   import asfr_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   logic ar_hs;
   logic stat_rd;
   assign ar_hs   = i_axi.arvalid && o_axi.arready;
   assign stat_rd = ar_hs && (i_axi.araddr inside {12'h04C, 12'h06C, 12'h08C, 12'h0AC});
   chk_read_answer: assert property (ar_hs |=> o_axi.rvalid) else $error("read answer late");
   chk_rdata_held: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
      else $error("read answer not held");
   chk_req_single: assert property (o_conv.req |=> !o_conv.req) else $error("request longer than one cycle");
   chk_single_slot: assert property (o_conv.req && o_conv.seq == 2'h3 |-> o_conv.slot == 2'h0)
      else $error("single slot sequencer stepped");
   chk_temp_diff: assert property (o_conv.req && o_conv.temp_source_select |-> !o_conv.diff)
      else $error("differential with sensor");
   chk_status_excl: assert property (stat_rd |=> !(o_axi.rdata[12] && o_axi.rdata[8]))
      else $error("full and empty together");
   chk_full_index: assert property (stat_rd |=> !o_axi.rdata[12] || o_axi.rdata[7:4] == o_axi.rdata[3:0])
      else $error("full with unequal indices");
   chk_end_fixed: assert property (ar_hs && i_axi.araddr == 12'h0A4 |=> o_axi.rdata[1])
      else $error("single slot end marker clear");
   chk_unmapped_read: assert property (ar_hs && i_axi.araddr == 12'h100 |=> o_axi.rresp == RESP_SLVERR
      && o_axi.rdata == 32'h0) else $error("unmapped read answered");
   chk_irq_single: assert property (o_raw_irq != 3'h0 |=> o_raw_irq == 3'h0)
      else $error("interrupt pulse too long");
   cover property (stat_rd ##1 o_axi.rdata[12]);
   cover property (o_conv.req && o_conv.temp_source_select);
   cover property (o_raw_irq != 3'h0);
endmodule : asfr_regs_asserts
bind asfr_regs asfr_regs_asserts i_asfr_regs_asserts (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_axi(i_axi),
   .o_axi(o_axi), .i_trigger(i_trigger), .o_conv(o_conv), .i_conv_res(i_conv_res),
   .i_seq0_res(i_seq0_res), .o_raw_irq(o_raw_irq));

// file: tb/asfr_regs_tb.sv
// Testbench: register access, sequencer runs, result order and FIFO flags
`timescale 1ns/1ps
module asfr_regs_tb;
   import asfr_pkg::*;
   logic           i_clk   = 1'b0;
   logic           i_rst_b = 1'b0;
   asfr_axi_in_t   ax      = '0;
   asfr_axi_out_t  o_axi;
   logic [3:1]     trig    = '0;
   asfr_conv_req_t conv;
   asfr_conv_res_t cres;
   asfr_conv_res_t s0res   = '0;
   logic [3:1]     irq;
   logic [2:0]     lat     = '0;
   logic [31:0]    seed    = 32'h0001_1D0E;
   int             miscompares  = 0;
   int             total_checks = 0;
   int             irq_cnt [4]  = '{default: 0};
   int             wp [4]       = '{default: 0};
   logic [1:0]     r;
   asfr_word_t     d;
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) for (int s = 1; s < 4; s++) irq_cnt[s] += int'(irq[s] === 1'b1);
   asfr_regs i_asfr_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_axi(ax), .o_axi(o_axi), .i_trigger(trig),
      .o_conv(conv), .i_conv_res(cres), .i_seq0_res(s0res), .o_raw_irq(irq));
   asfr_conv_model i_asfr_conv_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_conv(conv), .i_lat(lat), .o_res(cres));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic asfr_word_t exp_res(int s, int j, logic [3:0] m, logic [3:0] c);
      return {22'h0, 2'(s), 2'(j), c[3], c[0] & ~c[3], c[3] ? 4'hF : m};
   endfunction : exp_res
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input asfr_addr_t a, input asfr_word_t v, output logic [1:0] rs);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge i_clk);
      ax.awvalid <= 1'b1;
      ax.awaddr  <= a;
      ax.wvalid  <= 1'b1;
      ax.wdata   <= v;
      ax.wstrb   <= 4'hF;
      ax.bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge i_clk);
         ad = ad | (ax.awvalid & o_axi.awready);
         wd = wd | (ax.wvalid & o_axi.wready);
         ax.awvalid <= !ad;
         ax.wvalid  <= !wd;
      end
      do @(posedge i_clk); while (o_axi.bvalid !== 1'b1);
      rs = o_axi.bresp;
      ax.bready <= 1'b0;
   endtask : wr
   task automatic rd(input asfr_addr_t a, output asfr_word_t v, output logic [1:0] rs);
      @(posedge i_clk);
      ax.arvalid <= 1'b1;
      ax.araddr  <= a;
      do @(posedge i_clk); while (o_axi.arready !== 1'b1);
      ax.arvalid <= 1'b0;
      // Late rready at random, so the answer has to stand
      if (rnd() & 32'h1) @(posedge i_clk);
      ax.rready <= 1'b1;
      do @(posedge i_clk); while (o_axi.rvalid !== 1'b1);
      v = o_axi.rdata;
      rs = o_axi.rresp;
      ax.rready <= 1'b0;
   endtask : rd
   task automatic rdc(input asfr_addr_t a, input asfr_word_t m, input asfr_word_t e);
      asfr_word_t v;
      logic [1:0] rs;
      rd(a, v, rs);
      chk(v & m, e);
      chk(32'(rs), 32'(RESP_OKAY));
   endtask : rdc
   // Poll until the masked field shows the value, bounded
   task automatic wait_for(input asfr_addr_t a, input asfr_word_t m, input asfr_word_t e);
      asfr_word_t v;
      logic [1:0] rs;
      for (int i = 0; i < 100; i++) begin
         rd(a, v, rs);
         if ((v & m) === e) break;
      end
      chk(v & m, e);
   endtask : wait_for
   task automatic run(input int s, input bit force_full);
      int dep;
      int k;
      int ie;
      int c0;
      int n;
      int we;
      asfr_word_t sel;
      asfr_word_t ctl;
      asfr_word_t msk;
      dep = (s == 3) ? 1 : 4;
      msk = (s == 3) ? 32'hF : 32'hFFFF;
      k = force_full ? dep - 1 : int'(rnd() % dep);
      sel = rnd() & msk;
      ctl = ((rnd() & 32'hDDDD) | (32'h2 << (4 * k))) & msk;
      lat <= 3'(rnd());
      wr(OFF_SEL[s], sel, r);
      wr(OFF_CTL[s], ctl, r);
      ie = 0;
      for (int j = 0; j <= k; j++) ie += int'(ctl[4 * j + 2]);
      c0 = irq_cnt[s];
      n = (k == dep - 1) ? 2 : 1;
      we = (wp[s] + k + 1) % dep;
      for (int t = 0; t < n; t++) begin
         @(posedge i_clk);
         trig[s] <= 1'b1;
         @(posedge i_clk);
         trig[s] <= 1'b0;
         if (t == 0) wait_for(OFF_FSTAT[s], 32'h1F0, 32'(we) << 4);
         else begin
            wait_for(OFF_OVF, 32'h1 << s, 32'h1 << s);
            // Let the overflowing run finish before draining
            repeat (64) @(posedge i_clk);
         end
      end
      rdc(OFF_FSTAT[s], 32'h11FF, (n == 2 ? 32'h1000 : 32'h0) | (32'(we) << 4) | 32'(wp[s]));
      for (int j = 0; j <= k; j++) rdc(OFF_FIFO[s], 32'h3FF, exp_res(s, j, sel[4 * j +: 4], ctl[4 * j +: 4]));
      rdc(OFF_FSTAT[s], 32'h11FF, 32'h100 | (32'(we) << 4) | 32'(we));
      rd(OFF_FIFO[s], d, r);
      rdc(OFF_UNF, 32'h1 << s, 32'h1 << s);
      chk(32'(irq_cnt[s] - c0), 32'(ie * n));
      wr(OFF_OVF, 32'hF, r);
      wr(OFF_UNF, 32'hF, r);
      wp[s] = we;
   endtask : run
   initial begin
      repeat (50000) @(posedge i_clk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      for (int s = 0; s < 4; s++) rdc(OFF_FSTAT[s], 32'h11FF, FSTAT_RESET);
      rdc(OFF_CTL[3], 32'hF, 32'h2);
      rd(12'h100, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(OFF_FSTAT[1], 32'h0, r);
      chk(32'(r), 32'(RESP_SLVERR));
      for (int s = 1; s < 4; s++) begin
         wr(OFF_SEL[s], 32'hFFFF_FFFF, r);
         rdc(OFF_SEL[s], 32'hFFFF_FFFF, (s == 3) ? 32'hF : 32'hFFFF);
      end
      wr(OFF_CTL[3], 32'h0, r);
      rdc(OFF_CTL[3], 32'hFFFF_FFFF, 32'h2);
      for (int i = 0; i < 9; i++) begin
         @(posedge i_clk);
         s0res <= {1'b1, 10'(i * 7 + 1)};
         @(posedge i_clk);
         s0res.done <= 1'b0;
      end
      rdc(OFF_FSTAT[0], 32'h11FF, 32'h1000);
      rdc(OFF_OVF, 32'h1, 32'h1);
      for (int i = 0; i < 8; i++) rdc(OFF_FIFO[0], 32'h3FF, 32'(i * 7 + 1));
      wr(OFF_OVF, 32'hF, r);
      for (int t = 0; t < 4; t++) for (int s = 1; s < 4; s++) run(s, t == 0);
      report_and_stop();
   end
endmodule : asfr_regs_tb
